// ---- logic/iommu_req_attach.sv ----
`timescale 1ns/1ns
`include "iommu_req_regs.svh"
module iommu_req_attach import iommu_req_pkg::*; #(
   parameter int NUM_EP = 16,
   parameter int BUF_WORDS = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Endpoint access mode
   output logic [NUM_EP-1:0] ep_identity_o,
   output logic [NUM_EP-1:0] ep_attached_o
);
   localparam int EPW = $clog2(NUM_EP);
   localparam int BAW = $clog2(BUF_WORDS);

   // Byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   logic ack_r;
   logic [31:0] dat_r;
   wire logic acc = cyc_i && stb_i && !ack_r;
   wire logic wr = acc && we_i;
   wire logic [7:0] bad = {adr_i[7:2], 2'b00};
   wire logic wr_ctrl = wr && (bad == `OFF_CTRL);
   wire logic wr_len = wr && (bad == `OFF_LEN);
   wire logic wr_psm_lo = wr && (bad == `OFF_PSM_LO);
   wire logic wr_psm_hi = wr && (bad == `OFF_PSM_HI);
   wire logic wr_ins_lo = wr && (bad == `OFF_INS_LO);
   wire logic wr_ins_hi = wr && (bad == `OFF_INS_HI);
   wire logic wr_ine_lo = wr && (bad == `OFF_INE_LO);
   wire logic wr_ine_hi = wr && (bad == `OFF_INE_HI);
   wire logic wr_dom_s = wr && (bad == `OFF_DOM_S);
   wire logic wr_dom_e = wr && (bad == `OFF_DOM_E);
   wire logic wr_epcfg = wr && (bad == `OFF_EPCFG);
   wire logic wr_va_lo = wr && (bad == `OFF_VA_LO);
   wire logic wr_va_hi = wr && (bad == `OFF_VA_HI);
   wire logic wr_buf = wr && adr_i[7];

   ////////////////////////////////////////////////////////////////////
   // Sequencer state and configuration
   req_state_t state_r, state_nxt;
   logic [4:0] opt_r;
   logic [31:0] len_r, dom_s_r, dom_e_r;
   logic [63:0] psm_r, ins_r, ine_r, va_r;
   logic [EPW-1:0] epq_r;
   logic [BAW-1:0] rd_addr_r;
   logic [2:0] ld_idx_r;
   logic [7:0] type_r;
   logic [31:0] dom_r, ep_r, tail_r;
   logic rsv_nz_r, done_r;
   status_code_t status_r;
   logic [7:0] used_r;
   logic [31:0] rdata;

   wire logic idle = (state_r == ST_IDLE);
   // Go while busy is dropped so a request never changes mid-parse
   wire logic start = wr_ctrl && sel_i[0] && dat_i[`CTRL_GO] && idle;
   wire logic opt_in = opt_r[`CTRL_F_IN-1];
   wire logic opt_dom = opt_r[`CTRL_F_DOM-1];
   wire logic opt_byp = opt_r[`CTRL_BYPASS-1];
   wire logic opt_share = opt_r[`CTRL_SHARE-1];
   wire logic opt_move = opt_r[`CTRL_MOVE-1];

   ////////////////////////////////////////////////////////////////////
   // Request buffer; software fills it only while idle
   iommu_req_buf #(.WIDTH(32), .DEPTH(BUF_WORDS)) u_buf (
      .clk_i(clk_i),
      .we_i(wr_buf && idle),
      .waddr_i(adr_i[2 +: BAW]),
      .wdata_i(dat_i),
      .raddr_i(rd_addr_r),
      .rdata_o(rdata)
   );

   ////////////////////////////////////////////////////////////////////
   // Endpoint table
   logic [NUM_EP-1:0] bound_v, present_v, member_v, compat_v;
   logic [31:0] dom_v [NUM_EP];
   logic [7:0] props_v [NUM_EP];
   logic do_attach;
   wire logic ep_in = ep_r < 32'(NUM_EP);
   wire logic [EPW-1:0] ep_idx = ep_r[EPW-1:0];
   wire logic [7:0] ref_props = props_v[ep_idx];

   generate
      for (genvar g = 0; g < NUM_EP; g++) begin : g_slot
         iommu_ep_slot u_slot (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cfg_we_i(wr_epcfg && (dat_i[EPW-1:0] == EPW'(g))),
            .cfg_present_i(dat_i[16]),
            .cfg_props_i(dat_i[15:8]),
            .att_we_i(do_attach && (ep_idx == EPW'(g))),
            .att_dom_i(dom_r),
            .tgt_dom_i(dom_r),
            .ref_props_i(ref_props),
            .bound_o(bound_v[g]),
            .present_o(present_v[g]),
            .props_o(props_v[g]),
            .domain_o(dom_v[g]),
            .member_o(member_v[g]),
            .compat_o(compat_v[g])
         );
      end
   endgenerate

   // Unattached: identity only with bypass; attached domains start empty
   assign ep_identity_o = ~bound_v & {NUM_EP{opt_byp}};
   assign ep_attached_o = bound_v;

   ////////////////////////////////////////////////////////////////////
   // Attach decision
   wire logic [NUM_EP-1:0] sel_oh = {{(NUM_EP-1){1'b0}}, 1'b1} << ep_idx;
   wire logic [NUM_EP-1:0] others = member_v & ~sel_oh;
   wire logic occupied = |others;
   wire logic incompat = |(others & ~compat_v);
   wire logic ep_known = ep_in && present_v[ep_idx];
   wire logic ep_bound = bound_v[ep_idx];
   wire logic moved = ep_bound && (dom_v[ep_idx] != dom_r);
   wire logic same = ep_bound && !moved;
   // Driver should stay in range; device still guards it
   wire logic dom_bad = opt_dom &&
                        (dom_r < dom_s_r || dom_r > dom_e_r);
   wire logic [15:0] rd_len = len_r[15:0];
   wire logic [15:0] wl = len_r[31:16];
   wire logic is_att = (type_r == `T_ATTACH);
   wire logic known = (type_r >= `T_ATTACH) && (type_r <= `T_PROBE);
   // Head needs 4 bytes, tail 4 writable bytes, attach body 16
   wire logic parse_ok = (rd_len >= `HDR_LEN) &&
                         (wl >= 16'(`TAIL_LEN)) &&
                         (!is_att || rd_len >= `ATT_LEN);
   wire logic write_tail = parse_ok && known;
   // Priority: reserved, endpoint, range, rebind, share, properties
   wire status_code_t att_st =
      rsv_nz_r ? `S_INVAL :
      !ep_known ? `S_NOENT :
      dom_bad ? `S_RANGE :
      same ? `S_OK :
      (moved && !opt_move) ? `S_UNSUPP :
      (occupied && !opt_share) ? `S_UNSUPP :
      incompat ? `S_UNSUPP :
      `S_OK;
   // Other known types are not served by this block
   wire status_code_t st_nxt = is_att ? att_st : `S_UNSUPP;

   // Rebinding just overwrites the old domain: implicit detach
   assign do_attach = (state_r == ST_DECIDE) && write_tail && is_att &&
                      (att_st == `S_OK) && !same;

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (start) begin
               state_nxt = ST_PRIME;
            end
         end
         ST_PRIME: state_nxt = ST_LOAD;
         ST_LOAD: begin
            if (ld_idx_r == 3'd4) begin
               state_nxt = ST_DECIDE;
            end
         end
         ST_DECIDE: state_nxt = ST_IDLE;
      endcase
   end

   // State and read address; memory read lags the address by a cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         rd_addr_r <= '0;
         ld_idx_r <= 3'd0;
      end else begin
         state_r <= state_nxt;
         rd_addr_r <= idle ? '0 : rd_addr_r + BAW'(1);
         ld_idx_r <= (state_r == ST_LOAD) ? ld_idx_r + 3'd1 : 3'd0;
      end
   end

   // Field capture; fields are little-endian words
   always_ff @(posedge clk_i) begin
      if (rst_i || start) begin
         type_r <= 8'h00;
         dom_r <= 32'h0;
         ep_r <= 32'h0;
         rsv_nz_r <= 1'b0;
      end else if (state_r == ST_LOAD) begin
         unique case (ld_idx_r)
            3'd0: type_r <= rdata[7:0];
            3'd1: dom_r <= rdata;
            3'd2: ep_r <= rdata;
            default: rsv_nz_r <= rsv_nz_r | (|rdata);
         endcase
      end
   end

   // Completion; tail reserved bytes always zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
         status_r <= `S_OK;
         used_r <= 8'h00;
         tail_r <= 32'h0;
      end else if (state_r == ST_DECIDE) begin
         done_r <= 1'b1;
         used_r <= write_tail ? `TAIL_LEN : 8'h00;
         if (write_tail) begin
            status_r <= st_nxt;
            tail_r <= {24'h0, st_nxt};
         end
      end else if (start) begin
         done_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opt_r <= `CTRL_RST;
         len_r <= 32'h0;
         epq_r <= '0;
      end else begin
         if (wr_ctrl && sel_i[0]) begin
            opt_r <= dat_i[5:1];
         end
         if (wr_len && idle) begin
            len_r <= merge(len_r, dat_i, sel_i);
         end
         if (wr_epcfg) begin
            epq_r <= dat_i[EPW-1:0];
         end
      end
   end

   // Address limits and page mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         psm_r <= `PSM_RST;
         ins_r <= 64'h0;
         ine_r <= 64'hffff_ffff_ffff_ffff;
         dom_s_r <= 32'h0;
         dom_e_r <= 32'hffff_ffff;
      end else begin
         if (wr_psm_lo) psm_r[31:0] <= merge(psm_r[31:0], dat_i, sel_i);
         if (wr_psm_hi) psm_r[63:32] <= merge(psm_r[63:32], dat_i, sel_i);
         if (wr_ins_lo) ins_r[31:0] <= merge(ins_r[31:0], dat_i, sel_i);
         if (wr_ins_hi) ins_r[63:32] <= merge(ins_r[63:32], dat_i, sel_i);
         if (wr_ine_lo) ine_r[31:0] <= merge(ine_r[31:0], dat_i, sel_i);
         if (wr_ine_hi) ine_r[63:32] <= merge(ine_r[63:32], dat_i, sel_i);
         if (wr_dom_s) dom_s_r <= merge(dom_s_r, dat_i, sel_i);
         if (wr_dom_e) dom_e_r <= merge(dom_e_r, dat_i, sel_i);
      end
   end

   // Address under test
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         va_r <= 64'h0;
      end else begin
         if (wr_va_lo) va_r[31:0] <= merge(va_r[31:0], dat_i, sel_i);
         if (wr_va_hi) va_r[63:32] <= merge(va_r[63:32], dat_i, sel_i);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Mapping address check
   wire logic [63:0] gran = psm_r & (~psm_r + 64'h1);
   wire logic [63:0] eff_s = opt_in ? ins_r : 64'h0;
   wire logic [63:0] eff_e = opt_in ? ine_r : 64'hffff_ffff_ffff_ffff;
   wire logic va_ok = (|psm_r) && ((va_r & (gran - 64'h1)) == 64'h0) &&
                      (va_r >= eff_s) && (va_r <= eff_e);

   ////////////////////////////////////////////////////////////////////
   // Read mux and acknowledge; unmapped reads return zero
   wire logic [31:0] rd_mux =
      (bad == `OFF_CTRL) ? {26'h0, opt_r, 1'b0} :
      (bad == `OFF_STAT) ? {8'h0, used_r, status_r, 5'h0, va_ok,
                            done_r, !idle} :
      (bad == `OFF_LEN) ? len_r :
      (bad == `OFF_PSM_LO) ? psm_r[31:0] :
      (bad == `OFF_PSM_HI) ? psm_r[63:32] :
      (bad == `OFF_INS_LO) ? ins_r[31:0] :
      (bad == `OFF_INS_HI) ? ins_r[63:32] :
      (bad == `OFF_INE_LO) ? ine_r[31:0] :
      (bad == `OFF_INE_HI) ? ine_r[63:32] :
      (bad == `OFF_DOM_S) ? dom_s_r :
      (bad == `OFF_DOM_E) ? dom_e_r :
      (bad == `OFF_EPCFG) ? {14'h0, bound_v[epq_r], present_v[epq_r],
                             props_v[epq_r], 8'(epq_r)} :
      (bad == `OFF_EPDOM) ? dom_v[epq_r] :
      (bad == `OFF_VA_LO) ? va_r[31:0] :
      (bad == `OFF_VA_HI) ? va_r[63:32] :
      (bad == `OFF_TAIL) ? tail_r :
      32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
      end else begin
         ack_r <= acc;
         if (acc && !we_i) begin
            dat_r <= rd_mux;
         end
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;

   ////////////////////////////////////////////////////////////////////
   // Checks
   property p_unparse;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_DECIDE && !parse_ok) |=> done_r && used_r == 8'h00;
   endproperty
   a_unparse: assert property (p_unparse)
      else $error("unparsable request wrote a tail");

   property p_unknown;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_DECIDE && !known) |=>
         used_r == 8'h00 && $stable(tail_r);
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("unknown type was answered");

   property p_latency;
      @(posedge clk_i) disable iff (rst_i)
      start |=> (!done_r)[*7] ##1 done_r && idle;
   endproperty
   a_latency: assert property (p_latency)
      else $error("request not finished eight cycles after go");

   property p_rsv;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_DECIDE && parse_ok && is_att && rsv_nz_r) |=>
         status_r == `S_INVAL && $stable(bound_v);
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved bytes set but not rejected");

   property p_noent;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_DECIDE && parse_ok && is_att && !rsv_nz_r &&
       !ep_known) |=> status_r == `S_NOENT;
   endproperty
   a_noent: assert property (p_noent)
      else $error("unknown endpoint not rejected");

   property p_attach;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_DECIDE && parse_ok && is_att && att_st == `S_OK) |=>
         bound_v[$past(ep_idx)] && dom_v[$past(ep_idx)] == $past(dom_r) &&
         status_r == `S_OK;
   endproperty
   a_attach: assert property (p_attach)
      else $error("accepted attach not performed");

   property p_share;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_DECIDE && parse_ok && is_att && !rsv_nz_r &&
       ep_known && !dom_bad && !ep_bound && occupied && !opt_share) |=>
         status_r == `S_UNSUPP && !bound_v[$past(ep_idx)];
   endproperty
   a_share: assert property (p_share)
      else $error("shared domain refusal missing");

   property p_tail;
      @(posedge clk_i) disable iff (rst_i)
      $rose(done_r) && used_r == `TAIL_LEN |->
         tail_r[31:8] == 24'h0 && tail_r[7:0] == status_r;
   endproperty
   a_tail: assert property (p_tail)
      else $error("tail reserved bytes not zero");

   property p_reset;
      @(posedge clk_i)
      rst_i |=> bound_v == '0 && ep_attached_o == '0;
   endproperty
   a_reset: assert property (p_reset)
      else $error("endpoint attached after reset");

   property p_range;
      @(posedge clk_i) disable iff (rst_i)
      (!opt_in && psm_r == 64'h1) |-> va_ok;
   endproperty
   a_range: assert property (p_range)
      else $error("full space not mappable without input range");

   c_attach_ok: cover property (@(posedge clk_i) do_attach);
   c_rebind: cover property (@(posedge clk_i) do_attach && moved);
   c_unsupp: cover property (@(posedge clk_i)
      state_r == ST_DECIDE && write_tail && st_nxt == `S_UNSUPP);
   c_unparse: cover property (@(posedge clk_i)
      state_r == ST_DECIDE && !parse_ok);
endmodule : iommu_req_attach

// ---- inc/iommu_req_regs.svh ----
// Behaviour
// - Request is readable head, writable tail
// - Type codes: attach 1 to probe 5
// - Device error 3, out of range 5
// - Unparsable request returned with nothing written
// - Lowest page mask bit sets granularity
// - Domain range limits domains when offered
// - Addresses outside input range fail
// - No input range: full 64-bit space
// - Successful request gets OK status
// - Unknown type: no write, length zero
// - Ignore head reserved, zero tail reserved
// - Attach to unknown domain creates it
// - Many endpoints per domain, one domain each
// - Attach reserved nonzero gives invalid status
// - Unknown endpoint gives not-found status
// - Shared domain refused gives unsupported
// - Rebind is implicit detach, else unsupported
// - Incompatible properties give unsupported
// - Attach not rejected is carried out
// - Reset leaves every endpoint unattached
// - Bypass gives identity, else accesses fail
`ifndef IOMMU_REQ_REGS_SVH
`define IOMMU_REQ_REGS_SVH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_LEN 8'h08
`define OFF_PSM_LO 8'h0c
`define OFF_PSM_HI 8'h10
`define OFF_INS_LO 8'h14
`define OFF_INS_HI 8'h18
`define OFF_INE_LO 8'h1c
`define OFF_INE_HI 8'h20
`define OFF_DOM_S 8'h24
`define OFF_DOM_E 8'h28
`define OFF_EPCFG 8'h2c
`define OFF_EPDOM 8'h30
`define OFF_VA_LO 8'h34
`define OFF_VA_HI 8'h38
`define OFF_TAIL 8'h3c
`define OFF_BUF 8'h80
// Control fields
`define CTRL_GO 0
`define CTRL_F_IN 1
`define CTRL_F_DOM 2
`define CTRL_BYPASS 3
`define CTRL_SHARE 4
`define CTRL_MOVE 5
// Reset values
`define PSM_RST 64'h0000_0000_0000_1000
`define CTRL_RST 5'h0c
// Request types and lengths
`define T_ATTACH 8'h01
`define T_PROBE 8'h05
`define ATT_LEN 16'h0014
`define HDR_LEN 16'h0004
`define TAIL_LEN 8'h04
// Status codes
`define S_OK 8'h00
`define S_IOERR 8'h01
`define S_UNSUPP 8'h02
`define S_DEVERR 8'h03
`define S_INVAL 8'h04
`define S_RANGE 8'h05
`define S_NOENT 8'h06
`define S_FAULT 8'h07
`define S_NOMEM 8'h08
`endif

// ---- inc/iommu_req_pkg.sv ----
package iommu_req_pkg;
   // Request sequencer states
   typedef enum logic [1:0] {
      ST_IDLE, ST_PRIME, ST_LOAD, ST_DECIDE
   } req_state_t;
   typedef logic [7:0] status_code_t;
endpackage : iommu_req_pkg

// ---- logic/iommu_req_buf.sv ----
`timescale 1ns/1ns
module iommu_req_buf #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock
   input wire logic clk_i,
   // Write side
   input wire logic we_i,
   input wire logic [$clog2(DEPTH)-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   // Read side
   input wire logic [$clog2(DEPTH)-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   // Storage, no reset needed for data
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_r[waddr_i] <= wdata_i;
      end
   end

   // Registered read port
   always_ff @(posedge clk_i) begin
      rdata_o <= mem_r[raddr_i];
   end
endmodule : iommu_req_buf

// ---- logic/iommu_ep_slot.sv ----
`timescale 1ns/1ns
module iommu_ep_slot (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Software side configuration
   input wire logic cfg_we_i,
   input wire logic cfg_present_i,
   input wire logic [7:0] cfg_props_i,
   // Attach from the sequencer
   input wire logic att_we_i,
   input wire logic [31:0] att_dom_i,
   // Comparison inputs
   input wire logic [31:0] tgt_dom_i,
   input wire logic [7:0] ref_props_i,
   // State out
   output logic bound_o,
   output logic present_o,
   output logic [7:0] props_o,
   output logic [31:0] domain_o,
   output logic member_o,
   output logic compat_o
);
   // One domain per endpoint; rebinding overwrites old domain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bound_o <= 1'b0;
         domain_o <= 32'h0;
      end else if (att_we_i) begin
         bound_o <= 1'b1;
         domain_o <= att_dom_i;
      end
   end

   // Endpoint existence and probed properties
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         present_o <= 1'b0;
         props_o <= 8'h00;
      end else if (cfg_we_i) begin
         present_o <= cfg_present_i;
         props_o <= cfg_props_i;
      end
   end

   assign member_o = bound_o && (domain_o == tgt_dom_i);
   assign compat_o = (props_o == ref_props_i);
endmodule : iommu_ep_slot

// ---- verif/guest_drv_model.sv ----
`timescale 1ns/1ns
// Guest driver: posts requests and polls for completion
module guest_drv_model (
   // Clock
   input wire logic clk_i,
   // Bus master side
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   input wire logic [31:0] dat_i,
   input wire logic ack_i
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hf;
      dat_o = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////
   // One classic cycle; released address and data lines show inverted values
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
   endtask : xfer
   // Fill buffer, set lengths, start, poll done, fetch tail
   task automatic post(input logic [7:0] t, input logic [23:0] hr,
                       input logic [31:0] dm, ep, rs,
                       input logic [15:0] rl, wl, input logic [5:0] c,
                       output logic [31:0] st, tl);
      logic [31:0] q;
      xfer(1'b1, 8'h80, {hr, t}, q); // Head first, spare bytes
      xfer(1'b1, 8'h84, dm, q); // Little-endian body
      xfer(1'b1, 8'h88, ep, q);
      xfer(1'b1, 8'h8c, rs, q);
      xfer(1'b1, 8'h90, 32'h0, q);
      xfer(1'b1, 8'h08, {wl, rl}, q);
      xfer(1'b1, 8'h00, {26'h0, c[5:1], 1'b1}, q);
      st = 32'h0;
      while (st[1] !== 1'b1) xfer(1'b0, 8'h04, 32'h0, st);
      xfer(1'b0, 8'h3c, 32'h0, tl);
   endtask : post
endmodule : guest_drv_model

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wd, rd, q;
   logic [15:0] id_o, at_o;
   logic [5:0] ctl = 6'h18;
   int n_fail = 0, n_compared = 0, last = 0, d, e;
   int unsigned m_dom[16];
   bit m_bnd[16], m_pres[16];
   bit [7:0] m_pr[16];
   always #5 clk_i = ~clk_i;
   iommu_req_attach dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
      .dat_o(rd), .ack_o(ack), .ep_identity_o(id_o),
      .ep_attached_o(at_o));
   guest_drv_model drv (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd), .dat_i(rd),
      .ack_i(ack));
   ////////////////////////////////////////////////////////////////////
   task give_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task chk(input logic [63:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Reference model; -1 means buffers come back unwritten
   function automatic int predict(int t, int unsigned d, e, r, int rl,
                                  int wl);
      if (rl < 4 || wl < 4 || t < 1 || t > 5) return -1;
      if (t != 1) return 2;
      if (rl < 20) return -1;
      if (r != 0) return 4;
      if (e >= 16 || !m_pres[e]) return 6;
      if (ctl[2] && (d < 16 || d > 32)) return 5;
      if (m_bnd[e] && m_dom[e] == d) return 0;
      if (m_bnd[e] && !ctl[5]) return 2;
      for (int i = 0; i < 16; i++)
         if (i != e && m_bnd[i] && m_dom[i] == d)
            if (!ctl[4] || m_pr[i] != m_pr[e]) return 2;
      m_bnd[e] = 1'b1;
      m_dom[e] = d;
      return 0;
   endfunction : predict
   task run(input int t, input int unsigned d, e, r, input int rl, wl);
      logic [31:0] st, tl;
      logic [15:0] att;
      int x;
      x = predict(t, d, e, r, rl, wl);
      drv.post(8'(t), 24'($urandom), d, e, r, 16'(rl), 16'(wl), ctl,
               st, tl);
      if (x >= 0) last = x;
      chk({st[23:8], tl}, {(x < 0) ? 8'h0 : 8'h4, 8'(last), 24'h0,
          8'(last)});
      foreach (m_bnd[i]) att[i] = m_bnd[i];
      chk({id_o, at_o}, {ctl[3] ? ~att : 16'h0, att});
      $display("test type %0d ep %0d done", t, e);
   endtask : run
   // Address check: write address, then read flag
   task va(input logic [63:0] a, input logic ok);
      drv.xfer(1'b1, 8'h34, a[31:0], q);
      drv.xfer(1'b1, 8'h38, a[63:32], q);
      drv.xfer(1'b0, 8'h04, 32'h0, q);
      chk(q[2], ok);
   endtask : va
   ////////////////////////////////////////////////////////////////////
   initial begin
      #300000;
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
   end
   // Main sequence
   initial begin
      void'($urandom(92274));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      drv.xfer(1'b0, 8'h00, 32'h0, q);
      chk(q, 32'h18);
      drv.xfer(1'b0, 8'h0c, 32'h0, q);
      chk(q, 32'h1000);
      drv.xfer(1'b0, 8'h40, 32'h0, q);
      chk(q, 32'h0);
      chk({id_o, at_o}, {16'hffff, 16'h0});
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         m_pres[i] = 1'b1;
         m_pr[i] = (i == 4) ? 8'h22 : 8'h11;
         drv.xfer(1'b1, 8'h2c, {15'h0, 1'b1, m_pr[i], 8'(i)}, q);
      end
      // Domain window 16..32, used once the range option is on
      drv.xfer(1'b1, 8'h24, 32'h10, q);
      drv.xfer(1'b1, 8'h28, 32'h20, q);
      d = 16 + $urandom % 17;
      e = (d == 20) ? 21 : 20;
      run(1, d, 0, 0, 20, 2);
      run(1, d, 0, 0, 12, 4);
      for (int t = 0; t < 8; t++) run(t, d, 0, 0, 20, 4);
      run(1, d, 0, 0, 20, 4);
      run(1, d, 1, 1, 20, 4);
      run(1, d, 9, 0, 20, 4);
      run(1, d, 20, 0, 20, 4);
      run(1, 32'hffffffff, 1, 0, 20, 4);
      ctl = 6'h1c;
      run(1, 5, 2, 0, 20, 4);
      run(1, 33, 2, 0, 20, 4);
      run(1, d, 2, 0, 20, 4);
      ctl = 6'h0c;
      run(1, d, 3, 0, 20, 4);
      ctl = 6'h1c;
      run(1, d, 4, 0, 20, 4);
      run(1, e, 0, 0, 20, 4);
      ctl = 6'h3c;
      run(1, e, 0, 0, 20, 4);
      ctl = 6'h34;
      run(1, e, 3, 0, 20, 4);
      va(64'h2000, 1'b1);
      va(64'h2001, 1'b0);
      va(64'hffff_ffff_ffff_f000, 1'b1);
      drv.xfer(1'b1, 8'h0c, 32'h1, q);
      va(64'h2001, 1'b1);
      drv.xfer(1'b1, 8'h14, 32'h1000, q);
      drv.xfer(1'b1, 8'h1c, 32'hffff, q);
      drv.xfer(1'b1, 8'h20, 32'h0, q);
      drv.xfer(1'b1, 8'h00, 32'h36, q);
      va(64'h20000, 1'b0);
      va(64'h1000, 1'b1);
      $display("test address check done");
      give_verdict();
   end
endmodule : tb
